// ===== core/dscr_params.svh
`ifndef DSCR_PARAMS_SVH
`define DSCR_PARAMS_SVH

// ----------------------------------------------------------------
// word addresses of the common area
// ----------------------------------------------------------------
`define DSCR_ADDR_RUN_CMD 16'h0006
`define DSCR_ADDR_OP_STATUS 16'h000E
`define DSCR_ADDR_TRIP 16'h000F
`define DSCR_ADDR_IN_PINS 16'h0010
`define DSCR_ADDR_OUT_PINS 16'h0011
`define DSCR_ADDR_VOLT_IN 16'h0012
`define DSCR_ADDR_CURR_IN 16'h0013
`define DSCR_ADDR_SPEED 16'h0015
`define DSCR_ADDR_UNIT 16'h001A
`define DSCR_ADDR_POLES 16'h001B
`define DSCR_ADDR_FW_LEVEL 16'h001C

// ----------------------------------------------------------------
// run-command word fields
// ----------------------------------------------------------------
`define DSCR_CMD_STOP_BIT 0
`define DSCR_CMD_FWD_BIT 1
`define DSCR_CMD_REV_BIT 2
`define DSCR_CMD_FRST_BIT 3
`define DSCR_CMD_ESTOP_BIT 4
`define DSCR_CMD_WR_LSB 0
`define DSCR_CMD_WR_MSB 4
`define DSCR_CMD_SRC_LSB 6
`define DSCR_CMD_SRC_MSB 7
`define DSCR_CMD_FREF_LSB 8
`define DSCR_CMD_FREF_MSB 14
`define DSCR_CMD_NETERR_BIT 15
`define DSCR_CMD_RESET 5'h00

// ----------------------------------------------------------------
// operating-status word fields
// ----------------------------------------------------------------
`define DSCR_ST_DC_BRAKE_BIT 7
`define DSCR_ST_STOPPING_BIT 8
`define DSCR_ST_BRAKE_OPEN_BIT 10
`define DSCR_ST_PEND_FWD_BIT 11
`define DSCR_ST_PEND_REV_BIT 12
`define DSCR_ST_REM_RUN_BIT 13
`define DSCR_ST_REM_SPD_BIT 14

// ----------------------------------------------------------------
// trip word fields
// ----------------------------------------------------------------
`define DSCR_TR_OCT_PRI_BIT 0
`define DSCR_TR_OV_BIT 1
`define DSCR_TR_EXTERNAL_TRIP_A_BIT 2
`define DSCR_TR_ESTOP_BIT 3
`define DSCR_TR_UV_BIT 4
`define DSCR_TR_GF_OHT_BIT 6
`define DSCR_TR_MOT_TH_BIT 7
`define DSCR_TR_OL_BIT 8
`define DSCR_TR_HWDIAG_BIT 10
`define DSCR_TR_OCT_SEC_BIT 12
`define DSCR_TR_CARD_BIT 13
`define DSCR_TR_PHASE_BIT 14
`define DSCR_TR_DRV_OL_BIT 15

// ----------------------------------------------------------------
// speed-reference source codes meaning remote
// ----------------------------------------------------------------
`define DSCR_FREF_SERIAL 7'h1C
`define DSCR_FREF_CARD 7'h1D

`endif

// ===== core/dscr_pkg.sv
package dscr_pkg;

    // ------------------------------------------------------------
    // run/stop command source encoding
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DSCR_SRC_TERMINAL = 2'b00,
        DSCR_SRC_KEYPAD = 2'b01,
        DSCR_SRC_CARD = 2'b10,
        DSCR_SRC_SERIAL = 2'b11
    } dscr_src_t;

    // ------------------------------------------------------------
    // command pulses, msb first in run-command bit order
    // ------------------------------------------------------------
    typedef struct packed {
        logic estop;       // bit 4
        logic fault_reset; // bit 3
        logic rev;         // bit 2
        logic fwd;         // bit 1
        logic stop;        // bit 0
    } dscr_cmd_t;

    // live drive state flags
    typedef struct packed {
        logic stopped;
        logic fwd_running;
        logic rev_running;
        logic faulted;
        logic accel;
        logic decel;
        logic speed_arrived;
        logic dc_braking;
        logic stopping;
        logic brake_open;
    } dscr_run_state_t;

    // live trip flags
    typedef struct packed {
        logic overcurrent_trip_primary;
        logic overvoltage_trip;
        logic external_trip_a;
        logic emergency_stop_input;
        logic undervoltage_trip;
        logic ground_fault_trip;
        logic drive_overheat_trip;
        logic motor_thermal_trip;
        logic overload_trip;
        logic hardware_self_check_fault;
        logic overcurrent_trip_secondary;
        logic accessory_card_error;
        logic phase_loss_trip;
        logic drive_overload_trip;
    } dscr_trip_t;

    // live measurements
    typedef struct packed {
        logic [15:0] input_pin_levels;
        logic [15:0] output_pin_levels;
        logic [15:0] voltage_input_one;
        logic [15:0] voltage_input_two;
        logic [15:0] current_input_level;
        logic [15:0] shaft_speed_reading;
        logic [15:0] display_unit_select;
        logic [15:0] motor_pole_count;
        logic [15:0] custom_firmware_level;
    } dscr_meas_t;

    // word access request from the serial front end
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dscr_req_t;

    // word access answer
    typedef struct packed {
        logic valid;
        logic err;
        logic [15:0] rdata;
    } dscr_rsp_t;

    // whole state of the bank
    typedef struct packed {
        dscr_cmd_t run_cmd;
        logic pend_fwd;
        logic pend_rev;
        dscr_rsp_t rsp;
    } dscr_state_t;

endpackage : dscr_pkg

// ===== core/dscr_rise_det.sv
`timescale 1ns/1ps
`default_nettype none

// registered 0->1 detector, one pulse per rising bit
module dscr_rise_det #(
    parameter int W = 5
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] level, // levels to watch
    output logic [W-1:0] rise       // one-cycle pulses
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] prev;
        logic [W-1:0] rise;
    } dscr_rd_state_t;

    dscr_rd_state_t st_r; // registered state
    dscr_rd_state_t st_nxt; // next state

    // compare with last cycle's level
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = level;
        st_nxt.rise = level & ~st_r.prev;
    end

    // register, synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise = st_r.rise;

endmodule : dscr_rise_det

`default_nettype wire

// ===== core/dscr_regs.sv
`timescale 1ns/1ps
`default_nettype none

`include "dscr_params.svh"

// How it works
// - status bits 7,8,10 show braking, stopping, brake
// - status bits 11,12 show pending fwd/rev
// - status bits 13,14 flag remote run/speed source
// - trip bits 0-4 and 6 carry faults
// - trip bit 6 also overheat; 7,8 overloads
// - trip bits 10,12-15 carry further faults
// - stop acts on bit 0 rising
// - forward run acts on bit 1 rising
// - reverse run acts on bit 2 rising
// - bit 3 rising resets fault, bit 4 estops
// - bits 6-7 read run/stop source
// - bit 15 reads network error
module dscr_regs
    import dscr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire dscr_req_t req,              // word access request
    output dscr_rsp_t rsp,                  // answer, one cycle later
    input wire dscr_run_state_t run_state,  // live drive state
    input wire dscr_trip_t trip,            // live trip flags
    input wire dscr_meas_t meas,            // live readings
    input wire dscr_src_t run_src,          // run/stop source
    input wire logic [6:0] fref_src,        // speed-reference source
    input wire logic network_error,         // serial link error
    input wire logic volt_sel_two,          // 1: second voltage at 0x12
    output dscr_cmd_t cmd_pulse,            // one-cycle command pulses
    output logic pend_fwd,                  // forward command pending
    output logic pend_rev                   // reverse command pending
);

    // ------------------------------------------------------------
    // state and wires
    // ------------------------------------------------------------
    dscr_state_t st_r; // registered state
    dscr_state_t st_nxt; // next state
    logic [4:0] rise_w; // rising bits of command field
    dscr_cmd_t pulse_w; // same as struct
    logic [15:0] cmd_word; // run-command read value
    logic [15:0] status_word; // operating-status read value
    logic [15:0] trip_word; // trip read value
    logic remote_run; // run/stop from serial or card
    logic remote_spd; // speed reference from serial or card

    // ------------------------------------------------------------
    // edge detection on the written command bits
    // ------------------------------------------------------------
    dscr_rise_det #(
        .W(5)
    ) u_rise (
        .clk(clk),
        .rst_n(rst_n),
        .level(st_r.run_cmd),
        .rise(rise_w)
    );

    assign pulse_w = dscr_cmd_t'(rise_w);

    // ------------------------------------------------------------
    // read values
    // ------------------------------------------------------------
    // remote source decode
    always_comb begin
        remote_run = (run_src == DSCR_SRC_SERIAL) || (run_src == DSCR_SRC_CARD);
        // either remote speed-reference code counts
        remote_spd = (fref_src == `DSCR_FREF_SERIAL)
            || (fref_src == `DSCR_FREF_CARD);
    end

    // run-command word assembly
    always_comb begin
        cmd_word = 16'h0000;
        cmd_word[`DSCR_CMD_WR_MSB:`DSCR_CMD_WR_LSB] = st_r.run_cmd;
        cmd_word[`DSCR_CMD_SRC_MSB:`DSCR_CMD_SRC_LSB] = run_src;
        cmd_word[`DSCR_CMD_FREF_MSB:`DSCR_CMD_FREF_LSB] = fref_src;
        cmd_word[`DSCR_CMD_NETERR_BIT] = network_error;
    end

    // operating-status word assembly, bits 9 and 15 stay zero
    always_comb begin
        status_word = 16'h0000;
        status_word[0] = run_state.stopped;
        status_word[1] = run_state.fwd_running;
        status_word[2] = run_state.rev_running;
        status_word[3] = run_state.faulted;
        status_word[4] = run_state.accel;
        status_word[5] = run_state.decel;
        status_word[6] = run_state.speed_arrived;
        status_word[`DSCR_ST_DC_BRAKE_BIT] = run_state.dc_braking;
        status_word[`DSCR_ST_STOPPING_BIT] = run_state.stopping;
        status_word[`DSCR_ST_BRAKE_OPEN_BIT] = run_state.brake_open;
        status_word[`DSCR_ST_PEND_FWD_BIT] = st_r.pend_fwd;
        status_word[`DSCR_ST_PEND_REV_BIT] = st_r.pend_rev;
        status_word[`DSCR_ST_REM_RUN_BIT] = remote_run;
        status_word[`DSCR_ST_REM_SPD_BIT] = remote_spd;
    end

    // trip word assembly, bits 5, 9 and 11 stay zero
    always_comb begin
        trip_word = 16'h0000;
        trip_word[`DSCR_TR_OCT_PRI_BIT] = trip.overcurrent_trip_primary;
        trip_word[`DSCR_TR_OV_BIT] = trip.overvoltage_trip;
        trip_word[`DSCR_TR_EXTERNAL_TRIP_A_BIT] = trip.external_trip_a;
        trip_word[`DSCR_TR_ESTOP_BIT] = trip.emergency_stop_input;
        trip_word[`DSCR_TR_UV_BIT] = trip.undervoltage_trip;
        // shared bit: either fault sets it
        trip_word[`DSCR_TR_GF_OHT_BIT] = trip.ground_fault_trip
            | trip.drive_overheat_trip;
        trip_word[`DSCR_TR_MOT_TH_BIT] = trip.motor_thermal_trip;
        trip_word[`DSCR_TR_OL_BIT] = trip.overload_trip;
        trip_word[`DSCR_TR_HWDIAG_BIT] = trip.hardware_self_check_fault;
        trip_word[`DSCR_TR_OCT_SEC_BIT] = trip.overcurrent_trip_secondary;
        trip_word[`DSCR_TR_CARD_BIT] = trip.accessory_card_error;
        trip_word[`DSCR_TR_PHASE_BIT] = trip.phase_loss_trip;
        trip_word[`DSCR_TR_DRV_OL_BIT] = trip.drive_overload_trip;
    end

    // ------------------------------------------------------------
    // next state: access decode and pending commands
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp.valid = req.valid;
        st_nxt.rsp.err = 1'b0;
        st_nxt.rsp.rdata = 16'h0000;
        if (req.valid) begin
            unique case (req.addr)
                `DSCR_ADDR_RUN_CMD: begin
                    // only the command field is writable
                    if (req.write) begin
                        st_nxt.run_cmd = dscr_cmd_t'(req.wdata[`DSCR_CMD_WR_MSB:`DSCR_CMD_WR_LSB]);
                    end else begin
                        st_nxt.rsp.rdata = cmd_word;
                    end
                end
                // read-only words: a write just completes
                `DSCR_ADDR_OP_STATUS: begin
                    st_nxt.rsp.rdata = req.write ? 16'h0000 : status_word;
                end
                `DSCR_ADDR_TRIP: begin
                    st_nxt.rsp.rdata = req.write ? 16'h0000 : trip_word;
                end
                `DSCR_ADDR_IN_PINS: begin
                    // live input pin levels, writes dropped
                    st_nxt.rsp.rdata = req.write ? 16'h0000
                        : meas.input_pin_levels;
                end
                `DSCR_ADDR_OUT_PINS: begin
                    // live output pin levels, writes dropped
                    st_nxt.rsp.rdata = req.write ? 16'h0000
                        : meas.output_pin_levels;
                end
                `DSCR_ADDR_VOLT_IN: begin
                    // one address, two inputs: select picks
                    if (req.write) begin
                        st_nxt.rsp.rdata = 16'h0000;
                    end else if (volt_sel_two) begin
                        st_nxt.rsp.rdata = meas.voltage_input_two;
                    end else begin
                        st_nxt.rsp.rdata = meas.voltage_input_one;
                    end
                end
                `DSCR_ADDR_CURR_IN: begin
                    st_nxt.rsp.rdata = req.write ? 16'h0000 : meas.current_input_level;
                end
                `DSCR_ADDR_SPEED: begin
                    st_nxt.rsp.rdata = req.write ? 16'h0000 : meas.shaft_speed_reading;
                end
                `DSCR_ADDR_UNIT: begin
                    st_nxt.rsp.rdata = req.write ? 16'h0000 : meas.display_unit_select;
                end
                `DSCR_ADDR_POLES: begin
                    st_nxt.rsp.rdata = req.write ? 16'h0000 : meas.motor_pole_count;
                end
                `DSCR_ADDR_FW_LEVEL: begin
                    st_nxt.rsp.rdata = req.write ? 16'h0000 : meas.custom_firmware_level;
                end
                default: begin
                    // unmapped address
                    st_nxt.rsp.err = 1'b1;
                end
            endcase
        end
        // pending run direction; stop and estop win
        if (pulse_w.stop || pulse_w.estop) begin
            st_nxt.pend_fwd = 1'b0;
            st_nxt.pend_rev = 1'b0;
        end else if (pulse_w.fwd) begin
            st_nxt.pend_fwd = 1'b1;
            st_nxt.pend_rev = 1'b0;
        end else if (pulse_w.rev) begin
            st_nxt.pend_fwd = 1'b0;
            st_nxt.pend_rev = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rsp = st_r.rsp;
    assign cmd_pulse = pulse_w;
    assign pend_fwd = st_r.pend_fwd;
    assign pend_rev = st_r.pend_rev;

endmodule : dscr_regs

`default_nettype wire

// ===== core/dscr_regs_unused_marker.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== tb/dscr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// port checker for the command and status bank
// ------------------------------------------------------------
module dscr_regs_asserts
    import dscr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire dscr_req_t req,
    input wire dscr_rsp_t rsp,
    input wire dscr_run_state_t run_state,
    input wire dscr_trip_t trip,
    input wire dscr_meas_t meas,
    input wire dscr_src_t run_src,
    input wire logic [6:0] fref_src,
    input wire logic network_error,
    input wire logic volt_sel_two,
    input wire dscr_cmd_t cmd_pulse,
    input wire logic pend_fwd,
    input wire logic pend_rev
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [4:0] shadow_r; // command bits as last written
    logic [4:0] rise1_r;  // 0->1 seen when stored
    logic [4:0] rise2_r;  // same, when the pulse is due
    logic run_wr;
    logic rd;
    logic mapped;
    logic [7:0] st_w;     // status bits 14:7 as expected
    logic [15:0] run_w;   // run word as expected
    logic [15:0] trip_w;  // trip word as expected

    assign run_wr = req.valid && req.write && (req.addr == 16'h0006);
    assign rd = req.valid && !req.write;
    assign mapped = req.addr inside {16'h0006, 16'h000E, 16'h000F, 16'h0010, 16'h0011,
        16'h0012, 16'h0013, 16'h0015, 16'h001A, 16'h001B, 16'h001C};
    assign st_w = {(fref_src == 7'h1C) || (fref_src == 7'h1D), run_src[1], pend_rev, pend_fwd,
        run_state.brake_open, 1'b0, run_state.stopping, run_state.dc_braking};
    assign run_w = {network_error, fref_src, run_src, 1'b0, shadow_r};
    assign trip_w = {trip.drive_overload_trip, trip.phase_loss_trip, trip.accessory_card_error,
        trip.overcurrent_trip_secondary, 1'b0, trip.hardware_self_check_fault, 1'b0,
        trip.overload_trip, trip.motor_thermal_trip,
        trip.ground_fault_trip | trip.drive_overheat_trip, 1'b0, trip.undervoltage_trip,
        trip.emergency_stop_input, trip.external_trip_a, trip.overvoltage_trip,
        trip.overcurrent_trip_primary};

    // shadow of the stored command bits and their rising edges
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shadow_r <= 5'h00;
            rise1_r <= 5'h00;
            rise2_r <= 5'h00;
        end else begin
            shadow_r <= run_wr ? req.wdata[4:0] : shadow_r;
            rise1_r <= run_wr ? (req.wdata[4:0] & ~shadow_r) : 5'h00;
            rise2_r <= rise1_r;
        end
    end

    a_answer_next:
        assert property (req.valid |=> rsp.valid) else $error("answer missing");
    a_answer_cause:
        assert property (rsp.valid |-> $past(req.valid)) else $error("answer without request");
    a_unmapped_err:
        assert property (req.valid && !mapped |=> rsp.err && rsp.rdata == 16'h0000)
        else $error("unmapped access not refused");
    a_status_bits:
        assert property (rd && req.addr == 16'h000E |=> rsp.rdata[14:7] == $past(st_w))
        else $error("status word wrong");
    a_trip_map:
        assert property (rd && req.addr == 16'h000F |=> rsp.rdata == $past(trip_w))
        else $error("trip word wrong");
    a_run_word:
        assert property (rd && req.addr == 16'h0006 |=> rsp.rdata == $past(run_w))
        else $error("run word wrong");
    a_cmd_pulse:
        assert property (cmd_pulse == rise2_r) else $error("command pulse wrong");
    a_pend_fwd:
        assert property (cmd_pulse.fwd && !cmd_pulse.stop && !cmd_pulse.estop
            |=> pend_fwd && !pend_rev) else $error("forward not pending");
    a_pend_clear:
        assert property (cmd_pulse.stop || cmd_pulse.estop |=> !pend_fwd && !pend_rev)
        else $error("pending not cleared");

    c_fwd: cover property (cmd_pulse.fwd);
    c_rev_pend: cover property (pend_rev);
    c_refused: cover property (rsp.valid && rsp.err);
endmodule : dscr_regs_asserts

`default_nettype wire

// ===== tb/dscr_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// serial master: one word access at a time, strobe one cycle
module dscr_master_model
    import dscr_pkg::*;
(
    input wire logic clk,
    input wire dscr_rsp_t rsp,
    output dscr_req_t req
);
    initial req = '0;

    // present on a falling edge, then await the answer a few cycles
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                          output logic [15:0] q, output logic e, output logic ok);
        int n;
        @(negedge clk);
        req = '{valid: 1'b1, write: wr, addr: a, wdata: d};
        @(negedge clk);
        // released lines do not keep the last value
        req = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
        ok = 1'b0;
        q = 16'h0000;
        e = 1'b0;
        for (n = 0; n < 3 && !ok; n++) begin
            if (rsp.valid) begin
                ok = 1'b1;
                q = rsp.rdata;
                e = rsp.err;
            end else begin
                @(negedge clk);
            end
        end
    endtask : access
endmodule : dscr_master_model

`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, x, g) begin comparisons++; if ((g) !== (x)) begin err_count++; \
    $display("MISMATCH %s exp=%h got=%h", nm, x, g); end end

module tb_top
    import dscr_pkg::*;
;
    logic clk, rst_n, network_error, volt_sel_two, pend_fwd, pend_rev;
    dscr_req_t req;
    dscr_rsp_t rsp;
    dscr_run_state_t run_state;
    dscr_trip_t trip;
    dscr_meas_t meas;
    dscr_src_t run_src;
    logic [6:0] fref_src;
    dscr_cmd_t cmd_pulse;
    int err_count, comparisons;
    int pulse_cnt [5];
    logic [4:0] stored; // expected stored command bits
    logic pf, pr;       // expected pending flags
    logic [15:0] q;
    logic e, ok;
    logic [15:0] ro_addr [10] = '{16'h000E, 16'h000F, 16'h0010, 16'h0011, 16'h0012,
        16'h0013, 16'h0015, 16'h001A, 16'h001B, 16'h001C};
    logic [15:0] bad_addr [5] = '{16'h0007, 16'h0014, 16'h0019, 16'h001D, 16'hFFFF};
    int seq [6] = '{1, 2, 3, 4, 1, 0};

    dscr_regs u_dscr_regs (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp),
        .run_state(run_state), .trip(trip), .meas(meas), .run_src(run_src),
        .fref_src(fref_src), .network_error(network_error), .volt_sel_two(volt_sel_two),
        .cmd_pulse(cmd_pulse), .pend_fwd(pend_fwd), .pend_rev(pend_rev));
    dscr_master_model u_dscr_master_model (.clk(clk), .rsp(rsp), .req(req));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // count command pulses per bit
    always @(posedge clk) begin
        for (int i = 0; i < 5; i++) begin
            if (rst_n && cmd_pulse[i]) pulse_cnt[i]++;
        end
    end

    // expected read value from the live inputs
    function automatic logic [15:0] exp_rd(input logic [15:0] a);
        case (a)
            16'h0006: exp_rd = {network_error, fref_src, run_src, 1'b0, stored};
            16'h000E: exp_rd = {1'b0, (fref_src inside {7'h1C, 7'h1D}), run_src[1], pr, pf,
                run_state.brake_open, 1'b0, run_state.stopping, run_state.dc_braking,
                run_state.speed_arrived, run_state.decel, run_state.accel, run_state.faulted,
                run_state.rev_running, run_state.fwd_running, run_state.stopped};
            16'h000F: exp_rd = {trip.drive_overload_trip, trip.phase_loss_trip,
                trip.accessory_card_error, trip.overcurrent_trip_secondary, 1'b0,
                trip.hardware_self_check_fault, 1'b0, trip.overload_trip,
                trip.motor_thermal_trip, trip.ground_fault_trip | trip.drive_overheat_trip,
                1'b0, trip.undervoltage_trip, trip.emergency_stop_input, trip.external_trip_a,
                trip.overvoltage_trip, trip.overcurrent_trip_primary};
            16'h0010: exp_rd = meas.input_pin_levels;
            16'h0011: exp_rd = meas.output_pin_levels;
            16'h0012: exp_rd = volt_sel_two ? meas.voltage_input_two : meas.voltage_input_one;
            16'h0013: exp_rd = meas.current_input_level;
            16'h0015: exp_rd = meas.shaft_speed_reading;
            16'h001A: exp_rd = meas.display_unit_select;
            16'h001B: exp_rd = meas.motor_pole_count;
            16'h001C: exp_rd = meas.custom_firmware_level;
            default: exp_rd = 16'h0000;
        endcase
    endfunction : exp_rd

    task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
        u_dscr_master_model.access(wr, a, d, q, e, ok);
        `CHK("answer", 1'b1, ok)
    endtask : acc

    // read and compare; status bit 15 is left open
    task automatic rd_chk(input logic [15:0] a, input logic bad);
        acc(1'b0, a, 16'h0000);
        if (a == 16'h000E) q[15] = 1'b0;
        `CHK("rdata", bad ? 16'h0000 : exp_rd(a), q)
        `CHK("err", bad, e)
    endtask : rd_chk

    // new random live drive state
    task automatic shake(input int n);
        logic [159:0] m;
        m = {$urandom, $urandom, $urandom, $urandom, $urandom};
        @(negedge clk);
        run_state = 10'($urandom);
        trip = 14'($urandom);
        meas = m[143:0];
        run_src = dscr_src_t'(2'(n));
        fref_src = 7'($urandom_range(31, 26));
        network_error = 1'($urandom);
        volt_sel_two = 1'($urandom);
    endtask : shake

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    initial begin
        int k;
        int snap [5];
        logic [15:0] wd;
        rst_n = 1'b0;
        run_state = '0;
        trip = '0;
        meas = '0;
        run_src = DSCR_SRC_TERMINAL;
        fref_src = 7'h00;
        network_error = 1'b0;
        volt_sel_two = 1'b0;
        err_count = 0;
        comparisons = 0;
        stored = 5'h00;
        pf = 1'b0;
        pr = 1'b0;
        pulse_cnt = '{default: 0};
        void'($urandom(7));
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        // map: writes to read-only words ignored, unmapped refused
        for (int n = 0; n < 40; n++) begin
            shake(n);
            wd = ro_addr[$urandom_range(9)];
            acc(1'b1, wd, 16'($urandom));
            `CHK("wr_err", 1'b0, e)
            rd_chk(wd, 1'b0);
            rd_chk(16'h0006, 1'b0);
            rd_chk(16'h000E, 1'b0);
            rd_chk(bad_addr[n % 5], 1'b1);
        end
        $display("test map done");
        // each command: write 0, then the bit, then the bit again
        foreach (seq[j]) begin
            k = seq[j];
            acc(1'b1, 16'h0006, 16'h0000);
            stored = 5'h00;
            snap = pulse_cnt;
            wd = {11'($urandom), 5'h00} | (16'h0001 << k);
            acc(1'b1, 16'h0006, wd);
            stored = wd[4:0];
            repeat (4) @(negedge clk);
            if (k == 0 || k == 4) {pr, pf} = 2'b00;
            if (k == 1) {pr, pf} = 2'b01;
            if (k == 2) {pr, pf} = 2'b10;
            `CHK("pulse", snap[k] + 1, pulse_cnt[k])
            `CHK("pend", {pr, pf}, {pend_rev, pend_fwd})
            acc(1'b1, 16'h0006, wd);
            repeat (4) @(negedge clk);
            `CHK("pulses", snap.sum() + 1, pulse_cnt.sum())
            rd_chk(16'h000E, 1'b0);
            rd_chk(16'h0006, 1'b0);
        end
        // forward and reverse together: forward wins
        acc(1'b1, 16'h0006, 16'h0000);
        acc(1'b1, 16'h0006, 16'h0006);
        repeat (4) @(negedge clk);
        `CHK("both", 2'b01, {pend_rev, pend_fwd})
        $display("test commands done");
        print_verdict();
    end
endmodule : tb_top

bind dscr_regs dscr_regs_asserts u_dscr_regs_asserts (.clk(clk), .rst_n(rst_n), .req(req),
    .rsp(rsp), .run_state(run_state), .trip(trip), .meas(meas), .run_src(run_src),
    .fref_src(fref_src), .network_error(network_error), .volt_sel_two(volt_sel_two),
    .cmd_pulse(cmd_pulse), .pend_fwd(pend_fwd), .pend_rev(pend_rev));

`default_nettype wire
